// file: alsm_lane_mapper.sv
// Transport packer: places one frame of converter samples onto the lanes.
// Assumes frame_in comes from logic on clk; straps come from pins.
//
// Operation
// - Mode 1: 12-bit padded samples packed back to back, 0x00 filler.
// - Mode 2: one 8-bit sample per lane, lanes 0-3 carry A-D.
// - Mode 3: lane per channel, four 10-bit fields, five octets.
// - Mode 4: one 12-bit field per channel packed, single fills 0x0.
// - Mode 5: lane 0 carries A then B or 0x00; lane 1 C, D.
// - Mode 6 packs as mode 1 but on 64B/66B coding.
// - Mode 7: one 8-bit sample per lane, lanes 0-3 carry A-D.
// - Mode 8: lane per channel, two 12-bit fields, three octets.
// - Mode 9: two lanes per channel, even sample lower lane.
// - Samples leave MSB first; every tail bit is zero.
// - Lowest lanes are used; higher lanes powered down.
// - A 9-bit sample sits in the top of a 10- or 12-bit field; 8-bit fields keep its top 8 bits.
`timescale 1ns/1ps

module alsm_lane_mapper
	import alsm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Static straps
	input wire logic [3:0] link_mode_select,
	input wire logic [1:0] variant_select,
	// Frame of samples
	input wire alsm_frame_t frame_in,
	// Lane side
	output alsm_lanes_t lanes_out,
	output logic [ALSM_LANES-1:0] lane_power_up,
	output logic coding_64b66b,
	output logic mode_supported
);

	// ****************************************
	// Strap synchronisers
	// ****************************************
	logic [3:0] mode_meta_r;
	logic [3:0] mode_r;
	logic [1:0] var_meta_r;
	logic [1:0] var_r;

	// Straps are static, so a multi-bit two-stage capture is safe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_meta_r <= ALSM_MODE_RST;
			mode_r <= ALSM_MODE_RST;
			var_meta_r <= ALSM_VARIANT_RST;
			var_r <= ALSM_VARIANT_RST;
		end else begin
			mode_meta_r <= link_mode_select;
			mode_r <= mode_meta_r;
			var_meta_r <= variant_select;
			var_r <= var_meta_r;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	logic mode_ok;
	logic [1:0] var_idx;
	logic [3:0] lane_cnt;
	logic [2:0] channels;
	logic [7:0] lane_en_nxt;

	always_comb begin
		mode_ok = (mode_r >= ALSM_MODE_1) && (mode_r <= ALSM_MODE_9);
		case (var_r)
			ALSM_QUAD: begin
				var_idx = 2'h0;
				channels = 3'h4;
			end
			ALSM_DUAL: begin
				var_idx = 2'h1;
				channels = 3'h2;
			end
			default: begin
				var_idx = 2'h2;
				channels = 3'h1;
			end
		endcase
		lane_cnt = mode_ok ? ALSM_LANE_TBL[mode_r][var_idx] : 4'h0;
		// Lowest lanes first, the rest stay off
		lane_en_nxt = 8'((9'h001 << lane_cnt) - 9'h001);
	end

	// ****************************************
	// Sample packing
	// ****************************************
	logic [ALSM_CHANNELS-1:0][ALSM_SAMPLES-1:0][8:0] s;
	logic [95:0] str96;
	logic [47:0] str48;
	logic [31:0] str32;
	logic [ALSM_LANES-1:0][ALSM_LANE_BITS-1:0] word;

	always_comb begin
		// Missing channels read as zero, which yields the filler slots
		for (int c = 0; c < ALSM_CHANNELS; c++) begin
			s[c] = (c < int'(channels)) ? frame_in.samp[c] : '0;
		end
		str96 = '0;
		str48 = '0;
		str32 = '0;
		word = '0;
		case (mode_r)
			ALSM_MODE_1, ALSM_MODE_6: begin
				// Fields cross lane edges; single zeros give 0x00
				for (int c = 0; c < 4; c++) begin
					for (int k = 0; k < 2; k++) begin
						str96[95-24*c-12*k -: 12] = {s[c][k], 3'h0};
					end
				end
				for (int l = 0; l < 6; l++) begin
					word[l][39 -: 16] = str96[95-16*l -: 16];
				end
			end
			ALSM_MODE_2, ALSM_MODE_7: begin
				for (int c = 0; c < 4; c++) begin
					word[c][39 -: 8] = s[c][0][8:1];
				end
			end
			ALSM_MODE_3: begin
				for (int c = 0; c < 4; c++) begin
					for (int k = 0; k < 4; k++) begin
						word[c][39-10*k -: 10] = {s[c][k], 1'b0};
					end
				end
			end
			ALSM_MODE_4: begin
				for (int c = 0; c < 4; c++) begin
					str48[47-12*c -: 12] = {s[c][0], 3'h0};
				end
				for (int l = 0; l < 3; l++) begin
					word[l][39 -: 16] = str48[47-16*l -: 16];
				end
			end
			ALSM_MODE_5: begin
				for (int c = 0; c < 4; c++) begin
					str32[31-8*c -: 8] = s[c][0][8:1];
				end
				for (int l = 0; l < 2; l++) begin
					word[l][39 -: 16] = str32[31-16*l -: 16];
				end
			end
			ALSM_MODE_8: begin
				for (int c = 0; c < 4; c++) begin
					for (int k = 0; k < 2; k++) begin
						word[c][39-12*k -: 12] = {s[c][k], 3'h0};
					end
				end
			end
			ALSM_MODE_9: begin
				for (int c = 0; c < 4; c++) begin
					for (int k = 0; k < 2; k++) begin
						word[2*c+k][39 -: 8] = s[c][k][8:1];
					end
				end
			end
			default: begin
				word = '0;
			end
		endcase
		// Powered-down lanes carry nothing
		for (int l = 0; l < ALSM_LANES; l++) begin
			if (!lane_en_nxt[l]) begin
				word[l] = '0;
			end
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	// Bit 39 of each lane word is the first bit on the wire
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lanes_out <= '0;
		end else begin
			lanes_out.valid <= frame_in.valid && mode_ok;
			lanes_out.octets <= mode_ok ? ALSM_OCTET_TBL[mode_r]
				: ALSM_OCTETS_RST;
			if (frame_in.valid && mode_ok) begin
				lanes_out.data <= word;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lane_power_up <= ALSM_LANE_EN_RST;
			coding_64b66b <= 1'b0;
			mode_supported <= 1'b0;
		end else begin
			lane_power_up <= lane_en_nxt;
			coding_64b66b <= mode_ok && ALSM_CODE64_MASK[mode_r];
			mode_supported <= mode_ok;
		end
	end

endmodule

// file: alsm_lane_mapper_asserts.sv
// Checker for the lane mapper ports.
// Assumes straps are static between changes and reach logic via synchronisers.
`timescale 1ns/1ps
module alsm_lane_mapper_asserts
	import alsm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Straps and frame
	input wire logic [3:0] link_mode_select,
	input wire logic [1:0] variant_select,
	input wire alsm_frame_t frame_in,
	// Lane side
	input wire alsm_lanes_t lanes_out,
	input wire logic [ALSM_LANES-1:0] lane_power_up,
	input wire logic coding_64b66b,
	input wire logic mode_supported
);
	// ****
	// Helpers
	// ****
	logic [2:0] settle_r;
	logic [ALSM_LANES-1:0][ALSM_LANE_BITS-1:0] dark;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Decode is judged only once the strap synchronisers have settled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			settle_r <= 3'h0;
		else if ($changed(link_mode_select) || $changed(variant_select))
			settle_r <= 3'h0;
		else if (settle_r != 3'h7)
			settle_r <= settle_r + 3'h1;
	end
	always_comb begin
		for (int l = 0; l < ALSM_LANES; l++)
			dark[l] = {ALSM_LANE_BITS{!lane_power_up[l]}};
	end
	// ****
	// Properties
	// ****
	property p_answer;
		settle_r > 3'h3 && frame_in.valid && mode_supported |=> lanes_out.valid;
	endproperty
	a_answer: assert property (p_answer)
		else $error("frame not answered");
	property p_cause;
		!$past(frame_in.valid) |-> !lanes_out.valid;
	endproperty
	a_cause: assert property (p_cause)
		else $error("frame out without frame in");
	property p_pow;
		(lane_power_up & (lane_power_up + 8'h01)) == 8'h00;
	endproperty
	a_pow: assert property (p_pow)
		else $error("active lanes not lowest");
	property p_dark;
		lanes_out.valid |-> (lanes_out.data & dark) == '0;
	endproperty
	a_dark: assert property (p_dark)
		else $error("data on powered down lane");
	// On the edge that first sees a new strap, settle_r still holds its old count
	property p_code;
		settle_r > 3'h3 && !$changed(link_mode_select) |->
			coding_64b66b == (link_mode_select inside {[4:8]});
	endproperty
	a_code: assert property (p_code)
		else $error("line coding wrong");
	property p_supp;
		settle_r > 3'h3 && !$changed(link_mode_select) |->
			mode_supported == (link_mode_select inside {[1:9]});
	endproperty
	a_supp: assert property (p_supp)
		else $error("mode support wrong");
	property p_hold;
		$changed(lanes_out.data) |-> lanes_out.valid;
	endproperty
	a_hold: assert property (p_hold)
		else $error("lane data changed between frames");
	property p_tail;
		lanes_out.valid && lanes_out.octets == 3'h2 |->
			lanes_out.data[0][23:0] == 24'h0;
	endproperty
	a_tail: assert property (p_tail)
		else $error("tail bits not zero");
endmodule

bind alsm_lane_mapper alsm_lane_mapper_asserts u_chk (.clk(clk),
	.reset_n(reset_n), .link_mode_select(link_mode_select),
	.variant_select(variant_select), .frame_in(frame_in),
	.lanes_out(lanes_out), .lane_power_up(lane_power_up),
	.coding_64b66b(coding_64b66b), .mode_supported(mode_supported));

// file: alsm_pkg.sv
// Shared types and constants of the lane sample mapper.
// Assumes a single frame clock; mode and variant are static straps.
package alsm_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ALSM_CHANNELS = 4;
	localparam int ALSM_SAMPLES = 4;
	localparam int ALSM_LANES = 8;
	localparam int ALSM_LANE_BITS = 40;

	// ****************************************
	// Link mode codes
	// ****************************************
	localparam logic [3:0] ALSM_MODE_1 = 4'h1;
	localparam logic [3:0] ALSM_MODE_2 = 4'h2;
	localparam logic [3:0] ALSM_MODE_3 = 4'h3;
	localparam logic [3:0] ALSM_MODE_4 = 4'h4;
	localparam logic [3:0] ALSM_MODE_5 = 4'h5;
	localparam logic [3:0] ALSM_MODE_6 = 4'h6;
	localparam logic [3:0] ALSM_MODE_7 = 4'h7;
	localparam logic [3:0] ALSM_MODE_8 = 4'h8;
	localparam logic [3:0] ALSM_MODE_9 = 4'h9;

	// ****************************************
	// Product variant
	// ****************************************
	typedef enum logic [1:0] {
		ALSM_QUAD = 2'b00,
		ALSM_DUAL = 2'b01,
		ALSM_SINGLE = 2'b10
	} alsm_variant_t;

	// Active lanes per mode, columns quad, dual, single
	localparam logic [3:0] ALSM_LANE_TBL [10][3] = '{
		'{4'h0, 4'h0, 4'h0},
		'{4'h6, 4'h3, 4'h2},
		'{4'h4, 4'h2, 4'h1},
		'{4'h4, 4'h2, 4'h1},
		'{4'h3, 4'h2, 4'h1},
		'{4'h2, 4'h1, 4'h1},
		'{4'h6, 4'h3, 4'h2},
		'{4'h4, 4'h2, 4'h1},
		'{4'h4, 4'h2, 4'h1},
		'{4'h8, 4'h4, 4'h2}
	};

	// Octets per lane per frame
	localparam logic [2:0] ALSM_OCTET_TBL [10] = '{
		3'h0, 3'h2, 3'h1, 3'h5, 3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h1
	};

	// Modes that use 64B/66B line coding
	localparam logic [9:0] ALSM_CODE64_MASK = 10'h1F0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] ALSM_MODE_RST = 4'h0;
	localparam logic [1:0] ALSM_VARIANT_RST = 2'h0;
	localparam logic [7:0] ALSM_LANE_EN_RST = 8'h00;
	localparam logic [2:0] ALSM_OCTETS_RST = 3'h0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic [ALSM_CHANNELS-1:0][ALSM_SAMPLES-1:0][8:0] samp;
	} alsm_frame_t;

	typedef struct packed {
		logic valid;
		logic [2:0] octets;
		logic [ALSM_LANES-1:0][ALSM_LANE_BITS-1:0] data;
	} alsm_lanes_t;

endpackage

// file: alsm_rx_model.sv
// Receiver model: counts frames arriving on the lowest lanes.
// Assumes lane words are registered on clk by the packer.
`timescale 1ns/1ps
module alsm_rx_model
	import alsm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Lanes
	input wire alsm_lanes_t lanes,
	input wire logic [ALSM_LANES-1:0] lane_power_up,
	// Status
	output logic [15:0] rx_count_r
);
	// Only lane 0 upward is wired to the receiver
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rx_count_r <= 16'h0000;
		else if (lanes.valid && lane_power_up[0])
			rx_count_r <= rx_count_r + 16'h0001;
	end
endmodule

// file: testbench.sv
// Bench for the lane mapper: every mode and variant, random frames.
// Assumes the checker binds itself to the mapper.
`timescale 1ns/1ps
module testbench
	import alsm_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] mode = 4'h0;
	logic [1:0] vsel = 2'h0;
	alsm_frame_t fin = '0;
	alsm_lanes_t lanes;
	logic [7:0] pwr;
	logic code;
	logic supp;
	logic [15:0] rx;
	logic [31:0] seed = 32'h244F;
	logic [7:0][39:0] last = '0;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int sent = 0;
	initial forever #12.5 clk = ~clk;
	alsm_lane_mapper DUT (.clk(clk), .reset_n(reset_n),
		.link_mode_select(mode), .variant_select(vsel), .frame_in(fin),
		.lanes_out(lanes), .lane_power_up(pwr), .coding_64b66b(code),
		.mode_supported(supp));
	alsm_rx_model u_rx (.clk(clk), .reset_n(reset_n), .lanes(lanes),
		.lane_power_up(pwr), .rx_count_r(rx));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0][39:0] lx(int m, int v,
		logic [3:0][3:0][8:0] s);
		logic [319:0] t;
		logic [7:0][39:0] r;
		t = '0;
		for (int c = 0; c < 4; c++) begin
			if (c >= (v == 0 ? 4 : v == 1 ? 2 : 1))
				s[c] = '0;
			for (int n = 0; n < 4; n++)
				if (n < 2 || m == 3)
					case (m)
					1, 6: t[319-24*c-12*n -: 12] = {s[c][n], 3'h0};
					4: t[319-12*c -: 12] = {s[c][0], 3'h0};
					5: t[319-8*c -: 8] = s[c][0][8:1];
					2, 7: t[319-40*c -: 8] = s[c][0][8:1];
					3: t[319-40*c-10*n -: 10] = {s[c][n], 1'b0};
					8: t[319-40*c-12*n -: 12] = {s[c][n], 3'h0};
					default: t[319-40*(2*c+n) -: 8] = s[c][n][8:1];
					endcase
		end
		for (int l = 0; l < 8; l++)
			r[l] = l >= ALSM_LANE_TBL[m][v > 2 ? 2 : v] ? '0 :
				m inside {1, 4, 5, 6} ? {t[319-16*l -: 16], 24'h0} :
				t[319-40*l -: 40];
		return r;
	endfunction
	task automatic chk(logic [319:0] g, logic [319:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			complete_run;
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		for (int m = 0; m < 11; m++)
			for (int v = 0; v < 4; v++) begin
				mode = m[3:0];
				vsel = v[1:0];
				repeat (4) @(negedge clk);
				chk(pwr, m inside {[1:9]} ?
					(1 << ALSM_LANE_TBL[m][v > 2 ? 2 : v]) - 1 : 0);
				chk(code, m inside {[4:8]});
				chk(supp, m inside {[1:9]});
				chk(lanes.octets, m inside {[1:9]} ? ALSM_OCTET_TBL[m] : 0);
				for (int k = 0; k < 4; k++) begin
					fin.valid = 1'b1;
					for (int i = 0; i < 16; i++) begin
						seed = xs(seed);
						fin.samp[i/4][i%4] = k == 0 ? 9'h1FF : seed[8:0];
					end
					if (m inside {[1:9]})
						last = lx(m, v, fin.samp);
					@(negedge clk);
					chk(lanes.valid, m inside {[1:9]});
					chk(lanes.data, last);
					sent += m inside {[1:9]};
				end
				fin.valid = 1'b0;
			end
		@(negedge clk);
		chk(rx, sent);
		complete_run;
	end
endmodule
